// ### shared/qus_pkg.sv
// constants and carriers shared by the quad serial status block
package qus_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_NS = 25;
  localparam int BIT_NS = 8680;                         // one serial bit time in ns
  localparam int BIT_CYC = BIT_NS / CLK_NS;              // same bit time in whole clocks, rounds down
  localparam int IR_CYC = (BIT_CYC * 3) / 16;            // infrared pulse, 3/16 of a bit
  localparam logic [8:0] BAUD_LAST = 9'(BIT_CYC - 1);
  localparam logic [8:0] BAUD_HALF = 9'(BIT_CYC / 2 - 1);
  localparam logic [8:0] IR_EDGE = 9'(BIT_CYC - 1 - IR_CYC);
  localparam logic [1:0] Q_FULL = 2'h2;                  // two-entry buffers
  localparam logic [1:0] Q_EMPTY = 2'h0;
  localparam logic [3:0] TX_STOP_BIT = 4'h9;             // start + 8 data + stop
  localparam logic [3:0] RX_LAST_DATA = 4'h7;
  localparam logic [1:0] RTS_TRIG_FULL = 2'h0;           // trigger code that waits for full
  localparam int SUMMARY_TX_LSB = 0;
  localparam int SUMMARY_RX_LSB = 4;
  localparam logic [7:0] SUMMARY_RST = 8'hFF;            // all idle: tx bits show space, rx flags high
  localparam logic [3:0] GPI_RST = 4'hF;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } qus_rx_state_e;

  // per-channel control bits, from modem, feature and enhanced-feature registers
  typedef struct packed {
    logic       dtr_on;    // modem-control bit 0
    logic       rts_on;    // modem-control bit 1
    logic       ir_mode;   // modem-control bit 6
    logic       auto_rts;  // enhanced-feature bit 6
    logic       auto_cts;  // enhanced-feature bit 7
    logic       rx_ir_inv; // feature-control bit 2
    logic [1:0] rts_trig;  // feature-control bits 1:0
  } qus_ctrl_s;

  typedef struct packed {
    logic [1:0][7:0] buff;
    logic [1:0]      cnt;
    logic            rd;
    logic            wr;
    logic            busy;
    logic [9:0]      sh;
    logic [3:0]      bits;
    logic [8:0]      baud;
    logic            line;
    logic            ir;
  } qus_tx_s;

  typedef struct packed {
    logic [1:0][7:0] buff;
    logic [1:0]      cnt;
    logic            rd;
    logic            wr;
    qus_rx_state_e   st;
    logic [7:0]      sh;
    logic [3:0]      bits;
    logic [8:0]      baud;
    logic [8:0]      hold;
    logic            rts_n;
  } qus_rx_s;

  localparam qus_tx_s TX_RST = '{line: 1'b1, default: '0};
  localparam qus_rx_s RX_RST = '{st: RX_IDLE, rts_n: 1'b1, default: '0};
endpackage

// ### rtl/qus_top.sv
// four-channel serial status, summary byte and serial pin logic
`timescale 1ns/10ps
module qus_top
  import qus_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        fifo_status_select_n,
  input  wire qus_ctrl_s [NUM_CH-1:0]      ctrl,
  input  wire logic [NUM_CH-1:0]           serial_rx_in,
  input  wire logic [NUM_CH-1:0]           cts_in_n,
  input  wire logic [NUM_CH-1:0]           dsr_in_n,
  input  wire logic [NUM_CH-1:0]           tx_valid,
  input  wire logic [NUM_CH-1:0][7:0]      tx_data,
  output logic [NUM_CH-1:0]                tx_ready,
  output logic [NUM_CH-1:0]                rx_valid,
  output logic [NUM_CH-1:0][7:0]           rx_data,
  input  wire logic [NUM_CH-1:0]           rx_ready,
  output logic [NUM_CH-1:0]                transmit_space_flag_n,
  output logic [NUM_CH-1:0]                receive_data_flag_n,
  output logic                             transmit_ready_all_n,
  output logic                             receive_ready_all_n,
  output logic [7:0]                       data_out,
  output logic                             data_oe,
  output logic [NUM_CH-1:0]                serial_tx_out,
  output logic [NUM_CH-1:0]                infrared_only_tx_out,
  output logic [NUM_CH-1:0]                rts_out_n,
  output logic [NUM_CH-1:0]                dtr_out_n,
  output logic [NUM_CH-1:0]                gp_cts_n,
  output logic [NUM_CH-1:0]                gp_dsr_n
);
  localparam int SW = 3 * NUM_CH + 1;

  logic [SW-1:0]     sync1;
  logic [SW-1:0]     sync2;
  logic [NUM_CH-1:0] rx_s;
  logic [NUM_CH-1:0] cts_s;
  logic [NUM_CH-1:0] next_tx_flag_n;
  logic [NUM_CH-1:0] next_rx_flag_n;
  logic [7:0]        next_data_out;
  logic              next_data_oe;
  logic [NUM_CH-1:0] next_dtr_n;

  // two-flop synchronisers for every pin input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= {SW{1'b1}};
      sync2 <= {SW{1'b1}};
    end else begin
      sync1 <= {fifo_status_select_n, dsr_in_n, cts_in_n, serial_rx_in};
      sync2 <= sync1;
    end
  end

  assign rx_s  = sync2[NUM_CH-1:0];
  assign cts_s = sync2[2*NUM_CH-1:NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    qus_tx_s t;
    qus_tx_s n;
    qus_rx_s r;
    qus_rx_s m;
    logic    tx_push;
    logic    tx_pop;
    logic    rx_push;
    logic    rx_pop;
    logic    ir_pulse;
    logic    line;
    logic    thr_hit;

    // transmit buffer and serialiser
    always_comb begin
      n = t;
      tx_push = tx_valid[c] && t.cnt != Q_FULL;
      tx_pop = !t.busy && t.cnt != Q_EMPTY && !(ctrl[c].auto_cts && cts_s[c]);
      if (t.busy) begin
        if (t.baud == 9'h0) begin
          n.baud = BAUD_LAST;
          n.sh = {1'b1, t.sh[9:1]};
          n.bits = t.bits + 4'h1;
          if (t.bits == TX_STOP_BIT) begin
            n.busy = 1'b0;
          end
        end else begin
          n.baud = t.baud - 9'h1;
        end
      end else if (tx_pop) begin
        n.busy = 1'b1;
        n.baud = BAUD_LAST;
        n.bits = 4'h0;
        n.sh = {1'b1, t.buff[t.rd], 1'b0};
        n.rd = !t.rd;
      end
      if (tx_push) begin
        n.buff[t.wr] = tx_data[c];
        n.wr = !t.wr;
      end
      n.cnt = t.cnt + {1'b0, tx_push} - {1'b0, tx_pop};
      n.line = !n.busy || n.sh[0];
      n.ir = n.busy && !n.sh[0] && n.baud > IR_EDGE;
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        t <= TX_RST;
      end else begin
        t <= n;
      end
    end

    // receive decoder, deserialiser and buffer
    always_comb begin
      m = r;
      // decoder only listens in infrared mode, so a standard-mode idle
      // level leaves no stretch behind that fakes a start bit on switch-over
      ir_pulse = ctrl[c].ir_mode && (rx_s[c] ^ ctrl[c].rx_ir_inv);
      if (ir_pulse) begin
        m.hold = BAUD_LAST;
      end else if (r.hold != 9'h0) begin
        m.hold = r.hold - 9'h1;
      end
      line = ctrl[c].ir_mode ? !(ir_pulse || r.hold != 9'h0) : rx_s[c];
      rx_push = 1'b0;
      rx_pop = rx_ready[c] && r.cnt != Q_EMPTY;
      if (r.st != RX_IDLE && r.baud != 9'h0) begin
        m.baud = r.baud - 9'h1;
      end
      unique case (r.st)
        RX_IDLE: begin
          if (!line) begin
            m.st = RX_START;
            m.baud = BAUD_HALF;
          end
        end
        RX_START: begin
          if (r.baud == 9'h0) begin
            m.baud = BAUD_LAST;
            m.bits = 4'h0;
            m.st = line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (r.baud == 9'h0) begin
            m.baud = BAUD_LAST;
            m.sh = {line, r.sh[7:1]};
            m.bits = r.bits + 4'h1;
            if (r.bits == RX_LAST_DATA) begin
              m.st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (r.baud == 9'h0) begin
            m.st = RX_IDLE;
            rx_push = line && r.cnt != Q_FULL;
          end
        end
        default: m.st = RX_IDLE;
      endcase
      if (rx_push) begin
        m.buff[r.wr] = r.sh;
        m.wr = !r.wr;
      end
      if (rx_pop) begin
        m.rd = !r.rd;
      end
      m.cnt = r.cnt + {1'b0, rx_push} - {1'b0, rx_pop};
      thr_hit = (ctrl[c].rts_trig == RTS_TRIG_FULL) ? (m.cnt == Q_FULL) : (m.cnt != Q_EMPTY);
      m.rts_n = !(ctrl[c].rts_on && !(ctrl[c].auto_rts && thr_hit));
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        r <= RX_RST;
      end else begin
        r <= m;
      end
    end

    // channel pins, handshakes and flags
    assign serial_tx_out[c]         = ctrl[c].ir_mode ? t.ir : t.line;
    assign infrared_only_tx_out[c]  = t.ir;
    assign rts_out_n[c]             = r.rts_n;
    assign tx_ready[c]              = t.cnt != Q_FULL;
    assign rx_valid[c]              = r.cnt != Q_EMPTY;
    assign rx_data[c]               = r.buff[r.rd];
    assign transmit_space_flag_n[c] = t.cnt == Q_FULL;
    assign receive_data_flag_n[c]   = r.cnt == Q_EMPTY;
    assign next_tx_flag_n[c]        = n.cnt == Q_FULL;
    assign next_rx_flag_n[c]        = m.cnt == Q_EMPTY;

    // channel checks
    chk_tx_std_idle: assert property (@(posedge clk) disable iff (rst)
      !ctrl[c].ir_mode && !t.busy |-> serial_tx_out[c])
      else $error("standard transmit pin not high while idle");
    chk_ir_pin_idle: assert property (@(posedge clk) disable iff (rst)
      !t.busy |-> !infrared_only_tx_out[c] ##1 (t.busy || !infrared_only_tx_out[c]))
      else $error("infrared pin not low while idle");
    chk_ir_route: assert property (@(posedge clk) disable iff (rst)
      ctrl[c].ir_mode |-> serial_tx_out[c] == infrared_only_tx_out[c])
      else $error("infrared mode does not route encoder to transmit pin");
    chk_cts_stall: assert property (@(posedge clk) disable iff (rst)
      ctrl[c].auto_cts && cts_s[c] && !t.busy |=> !t.busy)
      else $error("transmit started while clear-to-send high");
    chk_rts_full: assert property (@(posedge clk) disable iff (rst)
      $past(ctrl[c].auto_rts) && r.cnt == Q_FULL |-> rts_out_n[c])
      else $error("request-to-send held low with full receive buffer");
    chk_rts_manual: assert property (@(posedge clk) disable iff (rst)
      !$past(ctrl[c].rts_on) |-> rts_out_n[c])
      else $error("request-to-send low without software enable");
    cov_tx_byte: cover property (@(posedge clk) disable iff (rst) tx_pop ##1 t.busy);
    cov_rx_push: cover property (@(posedge clk) disable iff (rst) rx_push);
    cov_cts_hold: cover property (@(posedge clk) disable iff (rst)
      ctrl[c].auto_cts && cts_s[c] && t.cnt != Q_EMPTY && !t.busy);
    cov_rts_full: cover property (@(posedge clk) disable iff (rst) ctrl[c].auto_rts && r.cnt == Q_FULL);
    chk_std_no_stretch: assert property (@(posedge clk) disable iff (rst)
      !ctrl[c].ir_mode && r.hold == 9'h0 |-> m.hold == 9'h0)
      else $error("infrared decoder active in standard mode");

    // combined views per channel
    chk_any_tx: assert property (@(posedge clk) disable iff (rst)
      !transmit_space_flag_n[c] |-> !transmit_ready_all_n)
      else $error("combined transmit-ready high while this channel has space");
    chk_any_rx: assert property (@(posedge clk) disable iff (rst)
      !receive_data_flag_n[c] |-> !receive_ready_all_n)
      else $error("combined receive-ready high while this channel has data");
    chk_summary_chan: assert property (@(posedge clk) disable iff (rst)
      data_out[SUMMARY_TX_LSB + c] == !transmit_space_flag_n[c] &&
      data_out[SUMMARY_RX_LSB + c] == receive_data_flag_n[c])
      else $error("summary byte bits do not match this channel flags");
  end

  // combined ready outputs, active low
  assign transmit_ready_all_n = &transmit_space_flag_n;
  assign receive_ready_all_n  = &receive_data_flag_n;

  // summary byte, bus drive and general purpose pins
  always_comb begin
    next_data_out = '0;
    next_data_out[SUMMARY_TX_LSB +: NUM_CH] = ~next_tx_flag_n;
    next_data_out[SUMMARY_RX_LSB +: NUM_CH] = next_rx_flag_n;
    next_data_oe = !sync2[SW-1];
    next_dtr_n = '1;
    for (int i = 0; i < NUM_CH; i++) begin
      next_dtr_n[i] = !ctrl[i].dtr_on;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out  <= SUMMARY_RST;
      data_oe   <= 1'b0;
      dtr_out_n <= '1;
      gp_cts_n  <= GPI_RST;
      gp_dsr_n  <= GPI_RST;
    end else begin
      data_out  <= next_data_out;
      data_oe   <= next_data_oe;
      dtr_out_n <= next_dtr_n;
      gp_cts_n  <= cts_s;
      gp_dsr_n  <= sync2[3*NUM_CH-1:2*NUM_CH];
    end
  end

  // top-level checks
  chk_tx_all_ready: assert property (@(posedge clk) disable iff (rst)
    g_ch[0].t.cnt != Q_FULL |-> !transmit_ready_all_n)
    else $error("combined transmit-ready high while a channel has space");
  chk_rx_all_ready: assert property (@(posedge clk) disable iff (rst)
    g_ch[1].r.cnt != Q_EMPTY |-> !receive_ready_all_n)
    else $error("combined receive-ready high while a channel has data");
  chk_summary_drive: assert property (@(posedge clk) disable iff (rst)
    !fifo_status_select_n |-> ##3 data_oe)
    else $error("summary byte not driven after select");
  chk_summary_release: assert property (@(posedge clk) disable iff (rst)
    fifo_status_select_n |-> ##3 !data_oe)
    else $error("summary byte still driven after select released");
  chk_summary_bits: assert property (@(posedge clk) disable iff (rst)
    data_out == {receive_data_flag_n, ~transmit_space_flag_n})
    else $error("summary byte out of step with channel flags");
  chk_dtr_gpo: assert property (@(posedge clk) disable iff (rst)
    ##1 dtr_out_n[0] == !$past(ctrl[0].dtr_on))
    else $error("data-terminal-ready does not follow software");
  chk_gpi_read: assert property (@(posedge clk) disable iff (rst)
    ##3 gp_dsr_n == $past(dsr_in_n, 3))
    else $error("data-set-ready not readable after sync");
  cov_summary_read: cover property (@(posedge clk) disable iff (rst) data_oe && data_out[SUMMARY_RX_LSB]);
endmodule // qus_top

// ### verification/qus_remote.sv
// remote serial transceiver model driving the line-side inputs
`timescale 1ns/10ps
module qus_remote
  import qus_pkg::*;
(
  input  wire logic          clk,
  output logic [NUM_CH-1:0]  serial_rx_in,
  output logic [NUM_CH-1:0]  cts_in_n,
  output logic [NUM_CH-1:0]  dsr_in_n
);
  // lines idle high so no false start is seen
  initial begin
    serial_rx_in = '1;
    cts_in_n = '1;
    dsr_in_n = '1;
  end

  // one frame after a gap: start, eight bits lsb first, stop
  task automatic send(input int ch, input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    repeat (gap) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      serial_rx_in[ch] = f[i];
      repeat (BIT_CYC) @(negedge clk);
    end
    serial_rx_in[ch] = 1'b1;
  endtask

  // infrared frame: a pulse against the idle level at the head of each zero bit
  task automatic send_ir(input int ch, input logic [7:0] b, input logic idle);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx_in[ch] = idle ^ !f[i];
      repeat (IR_CYC) @(negedge clk);
      serial_rx_in[ch] = idle;
      repeat (BIT_CYC - IR_CYC) @(negedge clk);
    end
  endtask
endmodule // qus_remote

// ### verification/qus_top_tb.sv
// self-checking bench for the quad serial status block
`timescale 1ns/10ps
module qus_top_tb;
  import qus_pkg::*;
  logic                      clk;
  logic                      rst;
  logic                      fsel_n;
  qus_ctrl_s [NUM_CH-1:0]    ctrl;
  logic [NUM_CH-1:0]         rx_in, cts_n, dsr_n, tx_valid, tx_ready, rx_valid, rx_ready;
  logic [NUM_CH-1:0][7:0]    tx_data, rx_data;
  logic [NUM_CH-1:0]         tflag_n, rflag_n, tx_out, ir_out, rts_n, dtr_n, gcts_n, gdsr_n;
  logic                      tall_n, rall_n, data_oe;
  logic [7:0]                data_out;
  int                        failures;
  int                        samples_checked;

  qus_top dut (.clk(clk), .rst(rst), .fifo_status_select_n(fsel_n), .ctrl(ctrl),
    .serial_rx_in(rx_in), .cts_in_n(cts_n), .dsr_in_n(dsr_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .transmit_space_flag_n(tflag_n), .receive_data_flag_n(rflag_n),
    .transmit_ready_all_n(tall_n), .receive_ready_all_n(rall_n), .data_out(data_out),
    .data_oe(data_oe), .serial_tx_out(tx_out), .infrared_only_tx_out(ir_out),
    .rts_out_n(rts_n), .dtr_out_n(dtr_n), .gp_cts_n(gcts_n), .gp_dsr_n(gdsr_n));
  qus_remote remote (.clk(clk), .serial_rx_in(rx_in), .cts_in_n(cts_n), .dsr_in_n(dsr_n));

  // clock at 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic push(input int ch, input logic [7:0] b);
    @(negedge clk);
    tx_data[ch] = b;
    tx_valid[ch] = 1'b1;
    @(negedge clk);
    tx_valid[ch] = 1'b0;
  endtask

  // idle levels while reset is held
  task automatic t_reset();
    chk(tx_out, 8'h0F);
    chk(ir_out, 8'h00);
    chk(tflag_n, 8'h00);
    chk(rflag_n, 8'h0F);
    chk(tall_n, 8'h00);
    chk(rall_n, 8'h01);
    chk(data_oe, 8'h00);
  endtask

  // select low drives summary after sync latency
  task automatic t_select();
    fsel_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(data_oe, 8'h01);
    chk(data_out, 8'hFF);
  endtask

  // fill every transmit buffer while clear-to-send holds them back
  task automatic t_fill();
    for (int c = 0; c < NUM_CH; c++) ctrl[c].auto_cts = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      push(c, 8'h5A);
      push(c, 8'h3C);
      if (c == 2) chk(tall_n, 8'h00);
    end
    @(negedge clk);
    chk(tx_ready, 8'h00);
    chk(tflag_n, 8'h0F);
    chk(tall_n, 8'h01);
    chk(data_out, 8'hF0);
    chk(tx_out, 8'h0F);
  endtask

  // releasing clear-to-send starts channel 0 frame
  task automatic t_tx();
    logic [9:0] f;
    int n;
    f = {1'b1, 8'h5A, 1'b0};
    remote.cts_in_n[0] = 1'b0;
    n = 0;
    while (tx_out[0] !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(tflag_n, 8'h0E);
    chk(tall_n, 8'h00);
    chk(data_out, 8'hF1);
    repeat (BIT_CYC / 2) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      chk(tx_out[0], f[i]);
      repeat (BIT_CYC) @(negedge clk);
    end
  endtask

  // modem outputs and general inputs
  task automatic t_modem();
    ctrl[0].dtr_on = 1'b1;
    remote.dsr_in_n = 4'h5;
    repeat (4) @(negedge clk);
    chk(dtr_n, 8'h0E);
    chk(gdsr_n, 8'h05);
    chk(gcts_n, 8'h0E);
  endtask

  // receive three bytes with automatic request-to-send throttling
  task automatic t_rx();
    ctrl[1].rts_on = 1'b1;
    ctrl[1].auto_rts = 1'b1;
    ctrl[1].rts_trig = 2'h1;
    repeat (2) @(negedge clk);
    chk(rts_n[1], 8'h00);
    remote.send(1, 8'hA5, 3);
    chk(rx_valid, 8'h02);
    chk(rx_data[1], 8'hA5);
    chk(rflag_n, 8'h0D);
    chk(rall_n, 8'h00);
    chk(data_out, 8'hD1);
    chk(rts_n[1], 8'h01);
    rx_ready[1] = 1'b1;
    @(negedge clk);
    rx_ready[1] = 1'b0;
    repeat (2) @(negedge clk);
    chk(rflag_n, 8'h0F);
    chk(rall_n, 8'h01);
    chk(rts_n[1], 8'h00);
    ctrl[1].rts_trig = RTS_TRIG_FULL;
    remote.send(1, 8'h3C, 3);
    chk(rts_n[1], 8'h00);
    remote.send(1, 8'hC3, 3);
    chk(rx_data[1], 8'h3C);
    chk(rts_n[1], 8'h01);
    rx_ready[1] = 1'b1;
    @(negedge clk);
    chk(rx_data[1], 8'hC3);
    chk(rts_n[1], 8'h00);
    @(negedge clk);
    rx_ready[1] = 1'b0;
    @(negedge clk);
    chk(rx_valid, 8'h00);
  endtask

  // infrared idle levels and inverted receive idle
  task automatic t_ir();
    ctrl[2].ir_mode = 1'b1;
    ctrl[3].ir_mode = 1'b1;
    ctrl[3].rx_ir_inv = 1'b1;
    repeat (3) @(negedge clk);
    chk(tx_out[2], 8'h00);
    chk(ir_out[3:2], 8'h00);
    repeat (BIT_CYC * 11) @(negedge clk);
    chk(rx_valid[3], 8'h00);
    remote.send_ir(3, 8'h96, 1'b1);
    chk(rx_valid[3], 8'h01);
    chk(rx_data[3], 8'h96);
    ctrl[2].ir_mode = 1'b0;
    fsel_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(tx_out[2], 8'h01);
    chk(data_oe, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    rst = 1'b1;
    fsel_n = 1'b1;
    ctrl = '0;
    tx_valid = '0;
    tx_data = '0;
    rx_ready = '0;
    repeat (12) @(negedge clk);
    t_reset();
    rst = 1'b0;
    t_select();
    t_fill();
    t_tx();
    t_modem();
    t_rx();
    t_ir();
    report_and_stop();
  end

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule // qus_top_tb
